// *** ecb_pkg.sv ***
package ecb_pkg;
  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CMD   = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_BUF   = 8'h0c;
  localparam logic [7:0] OFF_UNIT  = 8'h10;
  localparam logic [7:0] OFF_SHIDX = 8'h14;
  localparam logic [7:0] OFF_SHDAT = 8'h18;
  // ==========================================================
  // Control register fields.
  localparam int CB_COEN  = 0;
  localparam int CB_MODE  = 1;
  localparam int CB_NXEN  = 3;
  localparam int CB_INTCP = 4;
  localparam int CB_BRKEN = 5;
  localparam int CB_TRCEN = 6;
  // ==========================================================
  // Command register bits, each a one-shot action.
  localparam int CM_CAPT   = 0;
  localparam int CM_ARM    = 1;
  localparam int CM_DISARM = 2;
  localparam int CM_GO     = 3;
  localparam int CM_STOP   = 4;
  localparam int CM_BRK    = 5;
  localparam int CM_TRC    = 6;
  // ==========================================================
  // Status register fields.
  localparam int SB_EMU  = 0;
  localparam int SB_ARM  = 1;
  localparam int SB_CAPD = 2;
  localparam int SB_DIRT = 3;
  localparam int SB_PEND = 4;
  localparam int SB_GNT  = 5;
  localparam int SB_BUSY = 6;
  // ==========================================================
  // Grant modes and reset values.
  localparam logic [1:0] MODE_EMU = 2'h1;
  localparam logic [1:0] MODE_ANY = 2'h2;
  localparam logic COEN_RST_EARLY = 1'b1;
  localparam logic COEN_RST_LATE  = 1'b0;
  localparam int UNIT_W = 2;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CAPT  = 2'b01,
    ST_WBACK = 2'b11
  } ecb_state_t;
endpackage

// *** ecb_emu_ctrl.sv ***
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
// Contract
// - Mode 1 with bus enable grants the coprocessor only while emulating.
// - Earlier probes hold a request seen outside emulation, grant at start.
// - Mode 2 with bus enable grants the coprocessor at any time.
// - Mode resets to 1 on earlier probes, 2 on later; only 1 or 2.
// - After capture, interrogation reads and writes act on shadow copies.
// - External coprocessor: write back dirty shadows in mode 2, skip in 1.
// - Later probe answers operand requests only with extension enabled.
// - Capture runs only with the coprocessor bus enable set.
// - The user save buffer contents stay untouched across capture.
// - Internal coprocessor keeps shadows locally, buffer address cleared to zero at capture.
// - Internal coprocessor always writes back dirty shadows on resume.
// - At most four chained units, numbered 0 to 3.
// - After reset the current unit is the nearest one with a probe.
// - Local break and trace inputs derive from the shared lines.
// - The shared break line is driven only while armed; trace always.
// - Local break or trace input asserts only with its enable set.
// - One system-wide arm flag, set after reset.
// - Arm and disarm come from command, event or system match only.
// - An asserted shared break stops emulation where break-in is enabled.
// - Separate break and trace enables, both set after reset.
// - Trace match drives trace; break match stops emulation and drives neither line.
// - With bus enable clear the bus request line is ignored; operand requests are not.
module ecb_emu_ctrl #(
  parameter bit LATER_PROBE = 1'b0,
  parameter int NREGS       = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  probeFitted,
  input  wire logic        busReq,
  output logic             busGrant,
  input  wire logic        extOperandRequest,
  output logic             extOperandAck,
  output logic [$clog2(NREGS)-1:0] cpRegIdx,
  output logic             cpRegWe,
  output logic [31:0]      cpRegWrData,
  input  wire logic [31:0] cpRegRdData,
  input  wire logic        specArm,
  input  wire logic        specDisarm,
  input  wire logic        specBreak,
  input  wire logic        specTrace,
  input  wire logic        traceSpecMatch,
  input  wire logic        breakSpecMatch,
  input  wire logic        sharedBreakIn,
  input  wire logic        sharedTraceIn,
  output logic             sharedBreakOut,
  output logic             sharedBreakOe,
  output logic             sharedTraceOut,
  output logic             sharedTraceOe,
  output logic             localBreakIn,
  output logic             localTraceIn,
  output logic             emulating
);
  localparam int IW = $clog2(NREGS);
  localparam logic [IW-1:0] LAST = IW'(NREGS - 1);
  localparam logic [1:0] MODE_RST =
    LATER_PROBE ? ecb_pkg::MODE_ANY : ecb_pkg::MODE_EMU;
  localparam logic COEN_RST =
    LATER_PROBE ? ecb_pkg::COEN_RST_LATE : ecb_pkg::COEN_RST_EARLY;

  function automatic logic [ecb_pkg::UNIT_W-1:0] firstFitted(
    input logic [3:0] fit
  );
    logic [ecb_pkg::UNIT_W-1:0] u;
    u = '0;
    for (int i = 3; i >= 0; i--) begin
      if (fit[i]) begin
        u = ecb_pkg::UNIT_W'(i);
      end
    end
    return u;
  endfunction

  // ==========================================================
  // Bus slave.
  ecb_pkg::ecb_state_t st_r;
  ecb_pkg::ecb_state_t st_nxt;
  logic                   wrPend_r;
  logic [7:0]             wrAddr_r;
  logic [31:0]            hrdata_r;
  logic                   coEn_r;
  logic [1:0]             mode_r;
  logic                   nxEn_r;
  logic                   intCp_r;
  logic                   brkEn_r;
  logic                   trcEn_r;
  logic [31:0]            bufAddr_r;
  logic [ecb_pkg::UNIT_W-1:0] curUnit_r;
  logic                   unitInit_r;
  logic [IW-1:0]          shIdx_r;
  logic [31:0]            shadow [NREGS];
  logic                   emu_r;
  logic                   armed_r;
  logic                   captured_r;
  logic                   dirty_r;
  logic                   pending_r;
  logic                   busGrant_r;
  logic                   extAck_r;
  logic [IW-1:0]          cnt_r;
  logic                   bs1_r;
  logic                   bs2_r;
  logic                   ts1_r;
  logic                   ts2_r;
  logic                   brkDrv_r;
  logic                   trcDrv_r;

  wire        addrPhase = hsel && htrans[1] && hready && ce;
  wire [7:0]  rdAddr    = haddr[7:0];
  wire        wrStb     = wrPend_r && ce;
  wire        wrCtrl    = wrStb && (wrAddr_r == ecb_pkg::OFF_CTRL);
  wire        wrCmd     = wrStb && (wrAddr_r == ecb_pkg::OFF_CMD);
  wire        wrBuf     = wrStb && (wrAddr_r == ecb_pkg::OFF_BUF);
  wire        wrUnit    = wrStb && (wrAddr_r == ecb_pkg::OFF_UNIT);
  wire        wrShIdx   = wrStb && (wrAddr_r == ecb_pkg::OFF_SHIDX);
  wire        wrShDat   = wrStb && (wrAddr_r == ecb_pkg::OFF_SHDAT);
  wire [1:0]  modeIn    = hwdata[ecb_pkg::CB_MODE +: 2];
  wire        modeLegal = (modeIn == ecb_pkg::MODE_EMU) ||
                          (modeIn == ecb_pkg::MODE_ANY);
  wire        modeAny   = (mode_r == ecb_pkg::MODE_ANY);
  wire        modeEmu   = (mode_r == ecb_pkg::MODE_EMU);
  wire        idle      = (st_r == ecb_pkg::ST_IDLE);
  wire        capReq    = wrCmd && hwdata[ecb_pkg::CM_CAPT];
  wire        capStart  = capReq && coEn_r && idle && !emu_r &&
                          (intCp_r || modeAny);

  wire [31:0] ctrlVal = {25'h0, trcEn_r, brkEn_r, intCp_r, nxEn_r,
                         mode_r, coEn_r};
  wire [31:0] statVal = {22'h0, curUnit_r, 1'b0, !idle, busGrant_r,
                         pending_r, dirty_r, captured_r, armed_r, emu_r};
  wire [31:0] rdMux =
    (rdAddr == ecb_pkg::OFF_CTRL)  ? ctrlVal :
    (rdAddr == ecb_pkg::OFF_STAT)  ? statVal :
    (rdAddr == ecb_pkg::OFF_BUF)   ? bufAddr_r :
    (rdAddr == ecb_pkg::OFF_UNIT)  ? {30'h0, curUnit_r} :
    (rdAddr == ecb_pkg::OFF_SHIDX) ? 32'(shIdx_r) :
    (rdAddr == ecb_pkg::OFF_SHDAT) ? shadow[shIdx_r] : 32'h0;

  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else if (ce) begin
      wrPend_r <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_r <= rdAddr;
      end
      if (addrPhase && !hwrite) begin
        hrdata_r <= rdMux;
      end
    end
  end

  // ==========================================================
  // Configuration registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      coEn_r  <= COEN_RST;
      mode_r  <= MODE_RST;
      nxEn_r  <= 1'b0;
      intCp_r <= 1'b0;
      brkEn_r <= 1'b1;
      trcEn_r <= 1'b1;
    end else if (ce && wrCtrl) begin
      coEn_r  <= hwdata[ecb_pkg::CB_COEN];
      nxEn_r  <= hwdata[ecb_pkg::CB_NXEN];
      intCp_r <= hwdata[ecb_pkg::CB_INTCP];
      brkEn_r <= hwdata[ecb_pkg::CB_BRKEN];
      trcEn_r <= hwdata[ecb_pkg::CB_TRCEN];
      if (modeLegal) begin
        mode_r <= modeIn;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      curUnit_r  <= '0;
      unitInit_r <= 1'b0;
      bufAddr_r  <= 32'h0;
      shIdx_r    <= '0;
    end else if (ce) begin
      if (!unitInit_r) begin
        curUnit_r  <= firstFitted(probeFitted);
        unitInit_r <= 1'b1;
      end else if (wrUnit) begin
        curUnit_r <= hwdata[ecb_pkg::UNIT_W-1:0];
      end
      if (capStart && intCp_r) begin
        bufAddr_r <= 32'h0;
      end else if (wrBuf) begin
        bufAddr_r <= hwdata;
      end
      if (wrShIdx) begin
        shIdx_r <= hwdata[IW-1:0];
      end
    end
  end

  // ==========================================================
  // Capture, shadow copies and write-back.
  wire goReq    = wrCmd && hwdata[ecb_pkg::CM_GO];
  wire stopReq  = (wrCmd && hwdata[ecb_pkg::CM_STOP]) ||
                  localBreakIn || breakSpecMatch;
  wire goOk     = goReq && idle && !emu_r && !stopReq;
  wire wbNeed   = dirty_r && captured_r &&
                  (intCp_r || modeAny);
  wire shWr     = wrShDat && idle && !emu_r && captured_r;
  wire lastCnt  = (cnt_r == LAST);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ecb_pkg::ST_IDLE: begin
        if (capStart) begin
          st_nxt = ecb_pkg::ST_CAPT;
        end else if (goOk && wbNeed) begin
          st_nxt = ecb_pkg::ST_WBACK;
        end
      end
      ecb_pkg::ST_CAPT: begin
        if (lastCnt) begin
          st_nxt = ecb_pkg::ST_IDLE;
        end
      end
      ecb_pkg::ST_WBACK: begin
        if (lastCnt) begin
          st_nxt = ecb_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = ecb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= ecb_pkg::ST_IDLE;
      cnt_r <= '0;
    end else if (ce) begin
      st_r  <= st_nxt;
      cnt_r <= idle ? '0 : IW'(cnt_r + 1'b1);
    end
  end

  // Capture reads the coprocessor straight into the local copies,
  // so the user save buffer is never written.
  always_ff @(posedge clk) begin
    if (ce) begin
      if (st_r == ecb_pkg::ST_CAPT) begin
        shadow[cnt_r] <= cpRegRdData;
      end else if (shWr) begin
        shadow[shIdx_r] <= hwdata;
      end
    end
  end

  assign cpRegIdx    = cnt_r;
  assign cpRegWe     = (st_r == ecb_pkg::ST_WBACK);
  assign cpRegWrData = shadow[cnt_r];

  always_ff @(posedge clk) begin
    if (rst) begin
      emu_r      <= 1'b0;
      captured_r <= 1'b0;
      dirty_r    <= 1'b0;
    end else if (ce) begin
      if (stopReq) begin
        emu_r <= 1'b0;
      end else if (goOk && !wbNeed) begin
        emu_r <= 1'b1;
      end else if (st_r == ecb_pkg::ST_WBACK && lastCnt) begin
        emu_r <= 1'b1;
      end
      if (st_r == ecb_pkg::ST_CAPT && lastCnt) begin
        captured_r <= 1'b1;
      end
      if (shWr) begin
        dirty_r <= 1'b1;
      end else if ((goOk && !wbNeed) || st_r != ecb_pkg::ST_IDLE) begin
        dirty_r <= 1'b0;
      end
    end
  end
  assign emulating = emu_r;

  // ==========================================================
  // Coprocessor bus and operand handshakes.
  wire honour  = coEn_r && (modeAny || emu_r);
  wire pendSet = !LATER_PROBE && coEn_r && modeEmu &&
                 !emu_r && busReq;
  wire extOk   = LATER_PROBE && nxEn_r && (modeAny || emu_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      pending_r  <= 1'b0;
      busGrant_r <= 1'b0;
      extAck_r   <= 1'b0;
    end else if (ce) begin
      if (pendSet) begin
        pending_r <= 1'b1;
      end else if (busGrant_r || !coEn_r) begin
        pending_r <= 1'b0;
      end
      busGrant_r <= honour && (busReq || pending_r);
      extAck_r   <= extOk && extOperandRequest;
    end
  end
  assign busGrant      = busGrant_r;
  assign extOperandAck = extAck_r;

  // ==========================================================
  // Arm flag and shared break and trace lines.
  wire armSet = (wrCmd && hwdata[ecb_pkg::CM_ARM]) || specArm;
  wire armClr = (wrCmd && hwdata[ecb_pkg::CM_DISARM]) || specDisarm;

  always_ff @(posedge clk) begin
    if (rst) begin
      armed_r  <= 1'b1;
      bs1_r    <= 1'b0;
      bs2_r    <= 1'b0;
      ts1_r    <= 1'b0;
      ts2_r    <= 1'b0;
      brkDrv_r <= 1'b0;
      trcDrv_r <= 1'b0;
    end else if (ce) begin
      if (armSet) begin
        armed_r <= 1'b1;
      end else if (armClr) begin
        armed_r <= 1'b0;
      end
      bs1_r    <= sharedBreakIn;
      bs2_r    <= bs1_r;
      ts1_r    <= sharedTraceIn;
      ts2_r    <= ts1_r;
      brkDrv_r <= armed_r && ((wrCmd && hwdata[ecb_pkg::CM_BRK]) ||
                  specBreak);
      trcDrv_r <= (wrCmd && hwdata[ecb_pkg::CM_TRC]) || specTrace ||
                  traceSpecMatch;
    end
  end

  assign localBreakIn   = bs2_r && brkEn_r;
  assign localTraceIn   = ts2_r && trcEn_r;
  assign sharedBreakOut = brkDrv_r;
  assign sharedBreakOe  = brkDrv_r;
  assign sharedTraceOut = trcDrv_r;
  assign sharedTraceOe  = trcDrv_r;

  // ==========================================================
  // Assertions.
  a_mode_legal: assert property (
    @(posedge clk) disable iff (rst)
    modeEmu || modeAny)
    else $error("grant mode holds an illegal value");

  a_grant_emu_only: assert property (
    @(posedge clk) disable iff (rst)
    ce && coEn_r && modeEmu && !emu_r |=> !busGrant_r)
    else $error("mode 1 granted outside emulation");

  a_pend_store: assert property (
    @(posedge clk) disable iff (rst)
    ce && pendSet |=> pending_r)
    else $error("request outside emulation not held");

  a_grant_any: assert property (
    @(posedge clk) disable iff (rst)
    ce && coEn_r && modeAny && busReq |=> busGrant_r)
    else $error("mode 2 request not granted");

  a_disabled_ignore: assert property (
    @(posedge clk) disable iff (rst)
    ce && !coEn_r |=> !busGrant_r)
    else $error("grant while bus enable clear");

  a_ext_off: assert property (
    @(posedge clk) disable iff (rst)
    ce && !nxEn_r |=> !extOperandAck)
    else $error("operand ack while extension disabled");

  a_capt_needs_en: assert property (
    @(posedge clk) disable iff (rst)
    ce && idle && capReq && !coEn_r |=> st_r == ecb_pkg::ST_IDLE)
    else $error("capture started with bus enable clear");

  a_shadow_dirty: assert property (
    @(posedge clk) disable iff (rst)
    ce && shWr |=> dirty_r && shadow[$past(shIdx_r)] == $past(hwdata))
    else $error("shadow write not kept");

  a_skip_mode1: assert property (
    @(posedge clk) disable iff (rst)
    ce && goOk && !intCp_r && modeEmu |=>
      emu_r && st_r == ecb_pkg::ST_IDLE)
    else $error("mode 1 resume did not skip write-back");

  a_int_wback: assert property (
    @(posedge clk) disable iff (rst)
    ce && goOk && dirty_r && captured_r && intCp_r |=>
      st_r == ecb_pkg::ST_WBACK && !emu_r)
    else $error("internal resume skipped write-back");

  a_break_armed: assert property (
    @(posedge clk) disable iff (rst)
    ce && !armed_r |=> !sharedBreakOe)
    else $error("break line driven while disarmed");

  a_break_stops: assert property (
    @(posedge clk) disable iff (rst)
    ce && localBreakIn |=> !emu_r)
    else $error("enabled break did not stop emulation");
endmodule

// *** ecb_far_side.sv ***
`timescale 1ns/10ps
// ==========================================================
// Coprocessor register file and the neighbouring chained units.
module ecb_far_side #(
  parameter int NREGS = 8
) (
  input  wire logic                     clk,
  input  wire logic [$clog2(NREGS)-1:0] cpRegIdx,
  input  wire logic                     cpRegWe,
  input  wire logic [31:0]              cpRegWrData,
  output logic [31:0]                   cpRegRdData,
  input  wire logic                     breakOut,
  input  wire logic                     breakOe,
  input  wire logic                     traceOut,
  input  wire logic                     traceOe,
  input  wire logic                     otherBreak,
  input  wire logic                     otherTrace,
  output logic                          sharedBreak,
  output logic                          sharedTrace
);
  logic [31:0] regs [NREGS];
  initial begin
    for (int i = 0; i < NREGS; i++) begin
      regs[i] = 32'hc0de0000 | 32'(i);
    end
  end
  // ==========================================================
  // Registers answer at once and take write-back data on the edge.
  assign cpRegRdData = regs[cpRegIdx];
  always @(posedge clk) begin
    if (cpRegWe) begin
      regs[cpRegIdx] <= cpRegWrData;
    end
  end
  // ==========================================================
  // Shared lines are wired together and rest low when undriven.
  assign sharedBreak = (breakOe & breakOut) | otherBreak;
  assign sharedTrace = (traceOe & traceOut) | otherTrace;
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin \
  miscompares++; $display("FAIL %0t: got %h exp %h", $time, g, e); end end
module tb;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic        ce = 1'b1;
  logic        busReq = 0, extReq = 0, sArm = 0, sDis = 0, sBrk = 0;
  logic        sTrc = 0, tMatch = 0, bMatch = 0, othB = 0, othT = 0;
  wire         hreadyout, hresp, busGrant, extAck, cpWe, bOut, bOe;
  wire         tOut, tOe, lBrk, lTrc, emu, sBrkIn, sTrcIn;
  wire [31:0]  hrdata, cpWd, cpRd;
  wire [2:0]   cpIdx;
  int          miscompares = 0, nChecks = 0;
  always #25 clk = ~clk;
  ecb_emu_ctrl #(.LATER_PROBE(1'b0), .NREGS(8)) i_dut (
    .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .probeFitted(4'hc), .busReq(busReq),
    .busGrant(busGrant), .extOperandRequest(extReq),
    .extOperandAck(extAck), .cpRegIdx(cpIdx), .cpRegWe(cpWe),
    .cpRegWrData(cpWd), .cpRegRdData(cpRd), .specArm(sArm),
    .specDisarm(sDis), .specBreak(sBrk), .specTrace(sTrc),
    .traceSpecMatch(tMatch), .breakSpecMatch(bMatch),
    .sharedBreakIn(sBrkIn), .sharedTraceIn(sTrcIn),
    .sharedBreakOut(bOut), .sharedBreakOe(bOe), .sharedTraceOut(tOut),
    .sharedTraceOe(tOe), .localBreakIn(lBrk), .localTraceIn(lTrc),
    .emulating(emu));
  ecb_far_side #(.NREGS(8)) i_far (
    .clk(clk), .cpRegIdx(cpIdx), .cpRegWe(cpWe), .cpRegWrData(cpWd),
    .cpRegRdData(cpRd), .breakOut(bOut), .breakOe(bOe), .traceOut(tOut),
    .traceOe(tOe), .otherBreak(othB), .otherTrace(othT),
    .sharedBreak(sBrkIn), .sharedTrace(sTrcIn));
  // ==========================================================
  // Bus tasks.
  task automatic stopTest;
    $display("Checks %0d, miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    rd = hrdata;
    if (n >= 99) begin
      miscompares++;
      stopTest;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic cmd(input logic [31:0] c);
    xfer(1'b1, ecb_pkg::OFF_CMD, c);
  endtask
  task automatic chkRd(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask
  task automatic pollStat(input int b, input logic v);
    int n;
    n = 0;
    do begin xfer(1'b0, ecb_pkg::OFF_STAT, 32'h0); n++; end
      while (rd[b] !== v && n < 40);
    `CHK(rd[b], v)
  endtask
  // ==========================================================
  // Test sequence. Commands: 01 capture, 02 arm, 04 disarm, 08 go,
  // 10 stop. Control 0x63 is mode 1 with bus, break and trace enables.
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    chkRd(ecb_pkg::OFF_STAT, 32'h303, 32'h202);
    chkRd(ecb_pkg::OFF_CTRL, 32'h67, 32'h63);
    wr(ecb_pkg::OFF_CTRL, 32'h67);
    chkRd(ecb_pkg::OFF_CTRL, 32'h67, 32'h63);
    wr(ecb_pkg::OFF_CTRL, 32'h61);
    chkRd(ecb_pkg::OFF_CTRL, 32'h67, 32'h63);
    wr(ecb_pkg::OFF_UNIT, 32'h7);
    chkRd(ecb_pkg::OFF_UNIT, 32'hff, 32'h3);
    busReq <= 1'b1;
    cyc(3);
    `CHK(busGrant, 1'b0)
    chkRd(ecb_pkg::OFF_STAT, 32'h10, 32'h10);
    cmd(32'h08);
    pollStat(0, 1'b1);
    `CHK(busGrant, 1'b1)
    wr(ecb_pkg::OFF_CTRL, 32'h6b);
    extReq <= 1'b1;
    cyc(3);
    `CHK(extAck, 1'b0)
    cmd(32'h10);
    pollStat(0, 1'b0);
    cyc(2);
    `CHK(busGrant, 1'b0)
    wr(ecb_pkg::OFF_CTRL, 32'h65);
    cyc(2);
    `CHK(busGrant, 1'b1)
    wr(ecb_pkg::OFF_CTRL, 32'h64);
    cyc(2);
    `CHK(busGrant, 1'b0)
    busReq <= 1'b0;
    extReq <= 1'b0;
    wr(ecb_pkg::OFF_BUF, 32'h2000);
    cmd(32'h01);
    cyc(12);
    chkRd(ecb_pkg::OFF_STAT, 32'h4, 32'h0);
    wr(ecb_pkg::OFF_CTRL, 32'h65);
    cmd(32'h01);
    pollStat(2, 1'b1);
    for (int k = 0; k < 8; k++) begin
      wr(ecb_pkg::OFF_SHIDX, 32'(k));
      chkRd(ecb_pkg::OFF_SHDAT, '1, 32'hc0de0000 | 32'(k));
    end
    wr(ecb_pkg::OFF_SHIDX, 32'h3);
    wr(ecb_pkg::OFF_SHDAT, 32'h5a5a0003);
    chkRd(ecb_pkg::OFF_STAT, 32'h8, 32'h8);
    `CHK(i_far.regs[3], 32'hc0de0003)
    cmd(32'h08);
    pollStat(0, 1'b1);
    `CHK(i_far.regs[3], 32'h5a5a0003)
    cmd(32'h10);
    pollStat(0, 1'b0);
    wr(ecb_pkg::OFF_SHDAT, 32'h0bad0003);
    wr(ecb_pkg::OFF_CTRL, 32'h63);
    cmd(32'h08);
    pollStat(0, 1'b1);
    `CHK(i_far.regs[3], 32'h5a5a0003)
    cmd(32'h10);
    pollStat(0, 1'b0);
    wr(ecb_pkg::OFF_CTRL, 32'h73);
    wr(ecb_pkg::OFF_BUF, 32'h3000);
    cmd(32'h01);
    cyc(12);
    chkRd(ecb_pkg::OFF_BUF, '1, 32'h0);
    chkRd(ecb_pkg::OFF_SHDAT, '1, 32'h5a5a0003);
    wr(ecb_pkg::OFF_SHDAT, 32'h7e570003);
    cmd(32'h08);
    pollStat(0, 1'b1);
    `CHK(i_far.regs[3], 32'h7e570003)
    cmd(32'h10);
    pollStat(0, 1'b0);
    wr(ecb_pkg::OFF_CTRL, 32'h63);
    cmd(32'h04);
    chkRd(ecb_pkg::OFF_STAT, 32'h2, 32'h0);
    sBrk <= 1'b1;
    sTrc <= 1'b1;
    cyc(2);
    `CHK(bOe, 1'b0)
    `CHK(tOe, 1'b1)
    sBrk <= 1'b0;
    sTrc <= 1'b0;
    bMatch <= 1'b1;
    cyc(2);
    bMatch <= 1'b0;
    chkRd(ecb_pkg::OFF_STAT, 32'h2, 32'h0);
    sArm <= 1'b1;
    cyc(1);
    sArm <= 1'b0;
    chkRd(ecb_pkg::OFF_STAT, 32'h2, 32'h2);
    sBrk <= 1'b1;
    cyc(2);
    `CHK(bOe & bOut, 1'b1)
    sBrk <= 1'b0;
    tMatch <= 1'b1;
    cyc(3);
    `CHK({bOe, tOe}, 2'b01)
    tMatch <= 1'b0;
    sDis <= 1'b1;
    cyc(1);
    sDis <= 1'b0;
    chkRd(ecb_pkg::OFF_STAT, 32'h2, 32'h0);
    cmd(32'h02);
    chkRd(ecb_pkg::OFF_STAT, 32'h2, 32'h2);
    cmd(32'h08);
    pollStat(0, 1'b1);
    othB <= 1'b1;
    cyc(2);
    `CHK(lBrk, 1'b0)
    cyc(1);
    `CHK(lBrk, 1'b1)
    othB <= 1'b0;
    pollStat(0, 1'b0);
    wr(ecb_pkg::OFF_CTRL, 32'h43);
    cmd(32'h08);
    pollStat(0, 1'b1);
    othB <= 1'b1;
    cyc(4);
    `CHK(lBrk, 1'b0)
    chkRd(ecb_pkg::OFF_STAT, 32'h1, 32'h1);
    othB <= 1'b0;
    cmd(32'h10);
    pollStat(0, 1'b0);
    othT <= 1'b1;
    cyc(4);
    `CHK(lTrc, 1'b1)
    wr(ecb_pkg::OFF_CTRL, 32'h23);
    cyc(1);
    `CHK(lTrc, 1'b0)
    othT <= 1'b0;
    `CHK(hresp, 1'b0)
    ce <= 1'b0;
    sDis <= 1'b1;
    cyc(2);
    `CHK(hreadyout, 1'b0)
    sDis <= 1'b0;
    ce <= 1'b1;
    chkRd(ecb_pkg::OFF_STAT, 32'h2, 32'h2);
    stopTest;
  end
endmodule
